// file: design/rtc_port_defs.vh
// Constants for the real-time clock two-wire slave port.
// Assumes inclusion by bare name from the design files.
`ifndef RTC_PORT_DEFS_VH
`define RTC_PORT_DEFS_VH

`define DEV_ADDR        7'h68
`define DIR_WRITE       1'b0
`define DIR_READ        1'b1
`define PTR_W           6
`define PTR_RESET       6'h00
`define PTR_FIRST       6'h00
`define PTR_LAST        6'h3F
`define PTR_STEP        6'h01
`define SECONDS_ADDR    6'h00
`define SHADOW_LAST     6'h06
`define SHADOW_BYTES    7
`define BYTE_RESET      8'h00
`define BIT_LAST        3'h7
`define BIT_ZERO        3'h0
`define BIT_STEP        3'h1
`define RX_FULL         4'h8
`define RX_ZERO         4'h0
`define RX_STEP         4'h1
`define PH_ADDR         2'h0
`define PH_PTR          2'h1
`define PH_DATA         2'h2
`define PH_READ         2'h3

`endif

// file: design/pin_sync.v
// Two-flop synchroniser with one extra history stage per input bit.
// Assumes inputs are asynchronous to clk; stage one feeds only stage two.
module pin_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  input  wire             clk_en,
  // Pins in
  input  wire [WIDTH-1:0] pin_in,
  // Synchronised level and its previous value
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] level_prev
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  reg [WIDTH-1:0] hist_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Idle bus lines are high, so reset to one
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[i] <= 1'b1;
          sync_reg[i] <= 1'b1;
          hist_reg[i] <= 1'b1;
        end else if (clk_en) begin
          meta_reg[i] <= pin_in[i];
          sync_reg[i] <= meta_reg[i];
          hist_reg[i] <= sync_reg[i];
        end
      end
    end
  endgenerate

  assign level      = sync_reg;
  assign level_prev = hist_reg;

endmodule

// file: design/rtc_i2c_slave_port.v
// Two-wire serial slave port of a real-time clock.
// Assumes an external master drives the serial clock; timekeeping core,
// RAM and control register live outside and are reached by the
// write strobe, the live_time bus and the read address / read data pair.
`include "rtc_port_defs.vh"

module rtc_i2c_slave_port #(
  parameter SHADOW_W = 8 * `SHADOW_BYTES
) (
  // Clock, reset, enable
  input  wire                ref_clk,
  input  wire                rst_b,
  input  wire                clk_en,
  // Serial bus pins
  input  wire                scl_in,
  input  wire                sda_in,
  output wire                sda_out,
  output wire                sda_oe,
  // Live time and date from the counting core
  input  wire [SHADOW_W-1:0] live_time,
  // Register write side
  output wire                wr_stb,
  output wire [`PTR_W-1:0]   wr_addr,
  output wire [7:0]          wr_data,
  output wire                div_rst,
  // Register read side for addresses above the shadows
  output wire [`PTR_W-1:0]   rd_addr,
  input  wire [7:0]          rd_data,
  // Status
  output wire                busy
);

  ////////////////////////////////////////////////////////////////////////
  // States

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RECV = 5'b00010;
  localparam [4:0] ST_SACK = 5'b00100;
  localparam [4:0] ST_SEND = 5'b01000;
  localparam [4:0] ST_MACK = 5'b10000;

  ////////////////////////////////////////////////////////////////////////
  // Pin sampling

  wire [1:0] lvl;
  wire [1:0] lvl_prev;

  // Hundreds of samples per standard-mode bit; SCL halves of a few cycles are still caught
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk        (ref_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .pin_in     ({scl_in, sda_in}),
    .level      (lvl),
    .level_prev (lvl_prev)
  );

  wire scl_now  = lvl[1];
  wire scl_was  = lvl_prev[1];
  wire sda_now  = lvl[0];
  wire sda_was  = lvl_prev[0];

  wire scl_rise = scl_now & ~scl_was;
  wire scl_fall = ~scl_now & scl_was;
  wire start_det = scl_now & scl_was & sda_was & ~sda_now;
  wire stop_det  = scl_now & scl_was & ~sda_was & sda_now;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function [`PTR_W-1:0] ptr_inc;
    input [`PTR_W-1:0] p;
    begin
      if (p == `PTR_LAST) begin
        ptr_inc = `PTR_FIRST;
      end else begin
        ptr_inc = p + `PTR_STEP;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [4:0]          state_reg,   state_next;
  reg [1:0]          phase_reg,   phase_next;
  reg [3:0]          rx_cnt_reg,  rx_cnt_next;
  reg [2:0]          tx_cnt_reg,  tx_cnt_next;
  reg [7:0]          shift_reg,   shift_next;
  reg [`PTR_W-1:0]   ptr_reg,     ptr_next;
  reg                oe_reg,      oe_next;
  reg                out_reg;
  reg                wr_stb_reg,  wr_stb_next;
  reg [`PTR_W-1:0]   wr_addr_reg, wr_addr_next;
  reg [7:0]          wr_data_reg, wr_data_next;
  reg                div_rst_reg, div_rst_next;
  reg                busy_reg,    busy_next;
  reg [SHADOW_W-1:0] shadow_reg;

  // Byte to send: shadows for time and date, outside storage otherwise
  wire [7:0] tx_byte = (ptr_reg <= `SHADOW_LAST) ?
                       shadow_reg[ptr_reg[2:0]*8 +: 8] : rd_data;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always @* begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    rx_cnt_next  = rx_cnt_reg;
    tx_cnt_next  = tx_cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    oe_next      = oe_reg;
    wr_stb_next  = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    div_rst_next = 1'b0;
    busy_next    = busy_reg;
    if (start_det) begin
      // Also serves a repeated START from any state
      state_next  = ST_RECV;
      phase_next  = `PH_ADDR;
      rx_cnt_next = `RX_ZERO;
      oe_next     = 1'b0;
      busy_next   = 1'b1;
    end else if (stop_det) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
      busy_next  = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Also the silent state after a foreign address
          oe_next = 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && rx_cnt_reg != `RX_FULL) begin
            shift_next  = {shift_reg[6:0], sda_now};
            rx_cnt_next = rx_cnt_reg + `RX_STEP;
          end else if (scl_fall && rx_cnt_reg == `RX_FULL) begin
            rx_cnt_next = `RX_ZERO;
            case (phase_reg)
              `PH_ADDR: begin
                if (shift_reg[7:1] == `DEV_ADDR) begin
                  state_next = ST_SACK;
                  oe_next    = 1'b1;
                  phase_next = (shift_reg[0] == `DIR_READ) ? `PH_READ : `PH_PTR;
                end else begin
                  state_next = ST_IDLE;
                end
              end
              `PH_PTR: begin
                state_next = ST_SACK;
                oe_next    = 1'b1;
                ptr_next   = shift_reg[`PTR_W-1:0];
                phase_next = `PH_DATA;
              end
              default: begin
                // Commit as the acknowledge goes out
                state_next   = ST_SACK;
                oe_next      = 1'b1;
                wr_stb_next  = 1'b1;
                wr_addr_next = ptr_reg;
                wr_data_next = shift_reg;
                div_rst_next = (ptr_reg == `SECONDS_ADDR);
                ptr_next     = ptr_inc(ptr_reg);
              end
            endcase
          end
        end
        ST_SACK: begin
          // Held low through the whole ninth high period
          if (scl_fall) begin
            if (phase_reg == `PH_READ) begin
              state_next  = ST_SEND;
              oe_next     = ~tx_byte[7];
              shift_next  = {tx_byte[6:0], 1'b0};
              tx_cnt_next = `BIT_ZERO;
              ptr_next    = ptr_inc(ptr_reg);
            end else begin
              state_next = ST_RECV;
              oe_next    = 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (tx_cnt_reg == `BIT_LAST) begin
              state_next = ST_MACK;
              oe_next    = 1'b0;
            end else begin
              oe_next     = ~shift_reg[7];
              shift_next  = {shift_reg[6:0], 1'b0};
              tx_cnt_next = tx_cnt_reg + `BIT_STEP;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            shift_next[0] = sda_now;
          end else if (scl_fall) begin
            if (shift_reg[0] == 1'b0) begin
              state_next  = ST_SEND;
              oe_next     = ~tx_byte[7];
              shift_next  = {tx_byte[6:0], 1'b0};
              tx_cnt_next = `BIT_ZERO;
              ptr_next    = ptr_inc(ptr_reg);
            end else begin
              // Line left high so the master can STOP
              state_next = ST_IDLE;
              oe_next    = 1'b0;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= `PH_ADDR;
      rx_cnt_reg  <= `RX_ZERO;
      tx_cnt_reg  <= `BIT_ZERO;
      shift_reg   <= `BYTE_RESET;
      ptr_reg     <= `PTR_RESET;
      oe_reg      <= 1'b0;
      out_reg     <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_addr_reg <= `PTR_RESET;
      wr_data_reg <= `BYTE_RESET;
      div_rst_reg <= 1'b0;
      busy_reg    <= 1'b0;
      shadow_reg  <= {SHADOW_W{1'b0}};
    end else if (clk_en) begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      rx_cnt_reg  <= rx_cnt_next;
      tx_cnt_reg  <= tx_cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      oe_reg      <= oe_next;
      out_reg     <= 1'b0;
      wr_stb_reg  <= wr_stb_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      div_rst_reg <= div_rst_next;
      busy_reg    <= busy_next;
      if (start_det) begin
        // Frozen copy so a multi-byte read sees one instant
        shadow_reg <= live_time;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: only ever pulls low
  assign sda_out = out_reg;
  assign sda_oe  = oe_reg;
  assign wr_stb  = wr_stb_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign div_rst = div_rst_reg;
  // Pointer feeds the outside read port directly
  assign rd_addr = ptr_reg;
  assign busy    = busy_reg;

endmodule

// file: dv/rtc_port_monitor.sv
// Pin and write-side checker for the two-wire slave port.
// Assumes raw pin levels on scl_in and sda_in; bound below.
module rtc_port_monitor (
  // Clock and reset
  input wire       ref_clk,
  input wire       rst_b,
  // Bus pins
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  // Write side and status
  input wire       wr_stb,
  input wire [5:0] wr_addr,
  input wire       div_rst,
  input wire [5:0] rd_addr,
  input wire       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence start_c;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_c;
    scl_in && $rose(sda_in);
  endsequence
  //////////////////////////////////////////
  AST_OD_LOW: assert property (sda_out == 1'b0)
    else $error("sda drive value not low");
  AST_OE_SCL: assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  AST_BUSY_START: assert property (start_c |-> ##[1:5] busy)
    else $error("start not seen");
  AST_IDLE_STOP: assert property (stop_c |-> ##[1:5] !busy)
    else $error("stop not seen");
  AST_QUIET: assert property (!busy |-> !sda_oe)
    else $error("sda driven outside a transfer");
  AST_DIV_PAIR: assert property (div_rst |-> wr_stb && wr_addr == 6'h00)
    else $error("divider reset without seconds write");
  AST_DIV_SEC: assert property (wr_stb && wr_addr == 6'h00 |-> div_rst)
    else $error("seconds write without divider reset");
  AST_STB_ONE: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe longer than a cycle");
  AST_WR_ACK: assert property (wr_stb |-> ##[0:4] sda_oe)
    else $error("write not tied to acknowledge");
  AST_PTR_INC: assert property (wr_stb |-> ##[0:20] rd_addr == wr_addr + 6'h01)
    else $error("pointer did not step after write");
endmodule

bind rtc_i2c_slave_port rtc_port_monitor rtc_port_monitor_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wr_stb(wr_stb), .wr_addr(wr_addr),
  .div_rst(div_rst), .rd_addr(rd_addr), .busy(busy));

// file: dv/mst_model.sv
// Bus master model: makes the serial clock and pulls the data line.
// Assumes a pulled-up data wire built from both pull-downs.
module mst_model (
  input  wire  ref_clk,
  input  wire  sda_bus,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Low and high each four cycles, a 200 ns link period
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_pull <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    r = sda_bus;
    tick(2);
    scl <= 1'b0;
  endtask
  // Only from idle or with the clock low, so no false stop
  task automatic start();
    tick(1);
    sda_pull <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(1);
    sda_pull <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// file: dv/tb_rtc_i2c_slave_port.sv
// Self-checking bench for the two-wire slave port.
// Assumes mst_model as bus master and the bound pin checker.
module tb_rtc_i2c_slave_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic        clk_en;
  logic        scl;
  logic        sda_pull;
  wire         sda_bus;
  wire         sda_out;
  wire         sda_oe;
  logic [55:0] live_time;
  wire         wr_stb;
  wire  [5:0]  wr_addr;
  wire  [7:0]  wr_data;
  wire         div_rst;
  wire  [5:0]  rd_addr;
  logic [7:0]  rd_data;
  wire         busy;
  logic [7:0]  mem [0:63];
  int          errors = 0;
  int          num_checks = 0;
  int          wr_cnt = 0;
  int          div_cnt = 0;
  // Pull-up wins unless a party pulls low
  assign sda_bus = !(sda_oe | sda_pull);
  always #12.5 ref_clk = ~ref_clk;
  rtc_i2c_slave_port rtc_i2c_slave_port_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .clk_en(clk_en), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe(sda_oe), .live_time(live_time), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .div_rst(div_rst), .rd_addr(rd_addr), .rd_data(rd_data),
    .busy(busy));
  mst_model mst_model_i (.ref_clk(ref_clk), .sda_bus(sda_bus), .scl(scl),
    .sda_pull(sda_pull));
  // Outside register file behind the write strobe
  always @(posedge ref_clk) begin
    if (wr_stb) begin
      mem[wr_addr] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
    if (div_rst) div_cnt <= div_cnt + 1;
    rd_data <= mem[rd_addr];
  end
  //////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic a;
    mst_model_i.put_byte(d, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic recv(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    mst_model_i.get_byte(last, d);
    chk(d, exp);
  endtask
  //////////////////////////////////////////
  task automatic t_mismatch();
    int w;
    w = wr_cnt;
    mst_model_i.start();
    send(8'hA0, 1'b0);
    send(8'h11, 1'b0);
    mst_model_i.stop();
    chk(8'(wr_cnt - w), 8'h00);
  endtask
  task automatic t_write_wrap();
    int d;
    d = div_cnt;
    mst_model_i.start();
    send(8'hD0, 1'b1);
    send(8'h3E, 1'b1);
    send(8'hA5, 1'b1);
    send(8'h5A, 1'b1);
    send(8'h3C, 1'b1);
    mst_model_i.stop();
    chk(mem[6'h3E], 8'hA5);
    chk(mem[6'h3F], 8'h5A);
    chk(mem[6'h00], 8'h3C);
    chk(8'(div_cnt - d), 8'h01);
    chk({2'b00, rd_addr}, 8'h01);
  endtask
  // Pointer left at 01 by the write; no pointer byte here
  task automatic t_read_shadow();
    live_time <= 56'h66554433221100;
    mst_model_i.start();
    send(8'hD1, 1'b1);
    live_time <= 56'hFFFFFFFFFFFFFF;
    recv(1'b0, 8'h11);
    recv(1'b0, 8'h22);
    recv(1'b1, 8'h33);
    // Past the device's reaction time, so a missed NACK would drive
    repeat (4) @(posedge ref_clk);
    chk({7'h00, sda_bus}, 8'h01);
    chk({2'b00, rd_addr}, 8'h04);
    mst_model_i.stop();
  endtask
  task automatic t_rstart();
    mst_model_i.start();
    send(8'hD0, 1'b1);
    send(8'h3F, 1'b1);
    live_time <= 56'hC6C5C4C3C2C1C0;
    mst_model_i.start();
    send(8'hD1, 1'b1);
    recv(1'b0, 8'h5A);
    recv(1'b1, 8'hC0);
    mst_model_i.stop();
    chk({2'b00, rd_addr}, 8'h01);
  endtask
  //////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    live_time = 56'h0;
    rd_data = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({2'b00, rd_addr}, 8'h00);
    t_mismatch();
    t_write_wrap();
    t_read_shadow();
    t_rstart();
    tally_and_finish();
  end
  // Tests take about 1270 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end
endmodule
